// >>> design/ssp_top.sv
// Master/slave serial peripheral port with transmit and receive FIFOs
// Notes on behaviour
// - word size selectable as 8, 16 or 32 bits; exactly that many shifted.
// - chip-select active level is configurable, high or low.
// - chip-select is either software-driven or generated around each word.
// - clock phase and polarity configurable in both master and slave role.
// - clock rate programmable only as master; slave follows external clock.
// - as slave, clock pin is input and times all shifting and sampling.
// - as master, serial clock comes from reference clock via programmable divider.
// - full duplex, one bit back for every bit out per clock cycle.
// - master drives MOSI samples MISO; slave drives MISO samples MOSI.
// - as master, port drives serial clock and chip-select outward.
// - as slave, incoming chip-select qualifies participation in transfers.
// - as slave, chip-select assertion starts a frame of words, deassertion ends it.
// - slave role offers a switch that keeps the data output released.
// - transmit and receive each have an independent FIFO.
// - separate DMA requests for receive reads and transmit writes.
// - slave accepts consecutive words back to back without idle clocks.
// - with FIFOs, many words flow without per-word software action.
// - serial line activity never produces a wake-up request.
// - polarity sets idle level; phase 0 samples first edge, phase 1 second.
// - role bit cleared means master, set means slave.
// - phase 0: select leads first edge by a full cycle, first bit valid there.
// - words shift most significant bit first.
module ssp_top #(
  parameter int DATA_W = ssp_pkg::DATA_W,
  parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic role_select_bit_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic [1:0] word_size_i,
  input wire logic [7:0] clk_div_i,
  input wire logic cs_active_high_i,
  input wire logic cs_manual_i,
  input wire logic cs_manual_assert_i,
  input wire logic slave_out_disable_i,
  input wire logic dma_tx_en_i,
  input wire logic dma_rx_en_i,
  // Transmit word stream
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // Receive word stream
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // DMA requests
  output logic dma_tx_req_o,
  output logic dma_rx_req_o,
  // Status
  output logic busy_o,
  output logic slave_underrun_o,
  output logic slave_overrun_o,
  // Serial clock pin
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_o,
  // Chip-select pin
  input wire logic chip_select_line_i,
  output logic chip_select_line_o,
  output logic chip_select_line_oe_o,
  // Master-out data pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  // Master-in data pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o
);
  typedef enum logic [1:0] {M_IDLE, M_LEAD, M_XFER, M_LAG} ssp_mstate_t;

  ssp_mstate_t mstate;
  logic [7:0] half_cnt;
  logic half_tick;
  logic [5:0] edge_cnt;
  logic sclk_lvl;
  logic is_master;
  logic is_slave;
  logic [4:0] last_bit;
  logic [4:0] bit_cnt;
  logic fresh;
  logic [31:0] tx_sh;
  logic [31:0] rx_sh;
  logic [31:0] rx_next;
  logic [31:0] rx_word;
  logic [31:0] tx_load_word;
  logic din;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic shift_ev;
  logic m_lead_ev;
  logic m_trail_ev;
  logic s_lead_ev;
  logic s_trail_ev;
  logic sclk_prev;
  logic cs_prev;
  logic cs_in_act;
  logic s_frame;
  logic s_start;
  logic m_start;
  logic load_ev;
  logic word_done;
  logic m_cs_act;
  // FIFO connections
  logic [DATA_W-1:0] txf_data;
  logic txf_valid;
  logic txf_pop;
  logic rxf_ready;
  logic rxf_push;

  // Role decode: role bit clear selects master
  assign is_master = enable_i & ~role_select_bit_i;
  assign is_slave = enable_i & role_select_bit_i;

  // Last bit index for the selected size, unknown codes run as 32
  always_comb begin
    if (word_size_i == ssp_pkg::WSEL_8) begin
      last_bit = ssp_pkg::LAST_BIT_8;
    end else if (word_size_i == ssp_pkg::WSEL_16) begin
      last_bit = ssp_pkg::LAST_BIT_16;
    end else begin
      last_bit = ssp_pkg::LAST_BIT_32;
    end
  end

  // Left-align the outgoing word so bit 31 always holds the MSB
  always_comb begin
    if (word_size_i == ssp_pkg::WSEL_8) begin
      tx_load_word = {txf_data[7:0], 24'h000000};
    end else if (word_size_i == ssp_pkg::WSEL_16) begin
      tx_load_word = {txf_data[15:0], 16'h0000};
    end else begin
      tx_load_word = txf_data[31:0];
    end
    if (!txf_valid) begin
      tx_load_word = ssp_pkg::WORD_RESET; // Slave underrun sends zeros
    end
  end

  // Received word is right-aligned, upper bits zero
  assign rx_next = {rx_sh[30:0], din};
  always_comb begin
    if (word_size_i == ssp_pkg::WSEL_8) begin
      rx_word = {24'h000000, rx_next[7:0]};
    end else if (word_size_i == ssp_pkg::WSEL_16) begin
      rx_word = {16'h0000, rx_next[15:0]};
    end else begin
      rx_word = rx_next;
    end
  end

  // Half-period divider of the reference clock, master only
  assign half_tick = (half_cnt == clk_div_i);
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      half_cnt <= ssp_pkg::DIV_RESET;
    end else if (mstate == M_IDLE || half_tick) begin
      half_cnt <= ssp_pkg::DIV_RESET;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Master starts only when a word waits and the receive side has room,
  // so the receive FIFO can never overflow in master role
  assign m_start = is_master & (mstate == M_IDLE) & txf_valid & rxf_ready;

  // Master sequencer: lead half cycle, 2N clock edges, lag half cycle
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mstate <= M_IDLE;
      edge_cnt <= ssp_pkg::EDGE_RESET;
      sclk_lvl <= 1'b0;
    end else begin
      case (mstate)
        M_IDLE: begin
          sclk_lvl <= 1'b0;
          edge_cnt <= ssp_pkg::EDGE_RESET;
          if (m_start) begin
            mstate <= M_LEAD;
          end
        end
        M_LEAD: begin
          if (half_tick) begin
            mstate <= M_XFER;
          end
        end
        M_XFER: begin
          if (half_tick) begin
            sclk_lvl <= ~sclk_lvl;
            edge_cnt <= edge_cnt + 6'h01;
            if (edge_cnt == {last_bit, 1'b1}) begin
              mstate <= M_LAG;
            end
          end
        end
        M_LAG: begin
          if (half_tick) begin
            mstate <= M_IDLE;
          end
        end
        default: begin
          mstate <= M_IDLE;
        end
      endcase
      if (!is_master) begin
        mstate <= M_IDLE; // Role change or disable aborts the word
      end
    end
  end

  // Master edge events; sclk_lvl low means the next edge is a leading one
  assign m_lead_ev = (mstate == M_XFER) & half_tick & ~sclk_lvl;
  assign m_trail_ev = (mstate == M_XFER) & half_tick & sclk_lvl;

  // Slave pin history; inputs are synchronous to sys_clk_i
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      sclk_prev <= serial_clock_line_i;
      cs_prev <= cs_in_act;
    end
  end

  // Incoming select compared against the programmed active level
  assign cs_in_act = is_slave & (chip_select_line_i == cs_active_high_i);
  assign s_start = cs_in_act & ~cs_prev;
  // Edges only count while select was active before and after them
  assign s_frame = cs_in_act & cs_prev;
  assign s_lead_ev = s_frame & (serial_clock_line_i != clock_polarity_i) &
                     (sclk_prev == clock_polarity_i);
  assign s_trail_ev = s_frame & (serial_clock_line_i == clock_polarity_i) &
                      (sclk_prev != clock_polarity_i);

  // One edge pair for both roles; phase picks which edge samples
  assign lead_ev = m_lead_ev | s_lead_ev;
  assign trail_ev = m_trail_ev | s_trail_ev;
  assign sample_ev = clock_phase_i ? trail_ev : lead_ev;
  assign shift_ev = clock_phase_i ? lead_ev : trail_ev;

  // Master samples MISO, slave samples MOSI
  assign din = is_master ? miso_i : mosi_i;

  // Word boundary: slave reloads on the shift edge after a full word,
  // which lets the next word follow with no idle clock
  assign word_done = sample_ev & (bit_cnt == last_bit);
  assign load_ev = m_start | s_start |
                   (is_slave & shift_ev & (bit_cnt == ssp_pkg::BIT_RESET) & ~fresh);
  assign txf_pop = load_ev & txf_valid;
  assign rxf_push = word_done;

  // Shift registers and bit counter
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tx_sh <= ssp_pkg::WORD_RESET;
      rx_sh <= ssp_pkg::WORD_RESET;
      bit_cnt <= ssp_pkg::BIT_RESET;
      fresh <= 1'b0;
    end else begin
      if (m_start || s_start) begin
        tx_sh <= tx_load_word;
        bit_cnt <= ssp_pkg::BIT_RESET;
        fresh <= clock_phase_i; // Phase 1 first edge only drives
      end else begin
        if (shift_ev) begin
          if (bit_cnt != ssp_pkg::BIT_RESET) begin
            tx_sh <= {tx_sh[30:0], 1'b0};
          end else if (fresh) begin
            fresh <= 1'b0;
          end else if (is_slave) begin
            tx_sh <= tx_load_word;
          end
        end
        if (sample_ev) begin
          rx_sh <= rx_next;
          bit_cnt <= (bit_cnt == last_bit) ? ssp_pkg::BIT_RESET : bit_cnt + 5'h01;
        end
      end
    end
  end

  // Slave error pulses, registered
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      slave_underrun_o <= 1'b0;
      slave_overrun_o <= 1'b0;
    end else begin
      slave_underrun_o <= is_slave & load_ev & ~txf_valid;
      slave_overrun_o <= is_slave & word_done & ~rxf_ready;
    end
  end

  // Separate buffers per direction
  ssp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(txf_data),
    .out_valid_o(txf_valid),
    .out_ready_i(txf_pop)
  );

  ssp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(rx_word[DATA_W-1:0]),
    .in_valid_i(rxf_push),
    .in_ready_o(rxf_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // DMA requests are levels: room to write, data to read
  assign dma_tx_req_o = dma_tx_en_i & tx_ready_o;
  assign dma_rx_req_o = dma_rx_en_i & rx_valid_o;

  // Busy while a master word runs or a slave frame is open
  assign busy_o = (mstate != M_IDLE) | cs_in_act;

  // Master select: generated around each word or from software
  assign m_cs_act = cs_manual_i ? cs_manual_assert_i : (mstate != M_IDLE);

  // Pin drivers; everything released while disabled
  // No wake-up output exists, serial activity only feeds this logic
  assign serial_clock_line_o = clock_polarity_i ^ sclk_lvl;
  assign serial_clock_line_oe_o = is_master;
  assign chip_select_line_o = m_cs_act ? cs_active_high_i : ~cs_active_high_i;
  assign chip_select_line_oe_o = is_master;
  assign mosi_o = tx_sh[31];
  assign mosi_oe_o = is_master & m_cs_act;
  assign miso_o = tx_sh[31];
  assign miso_oe_o = cs_in_act & ~slave_out_disable_i;
  // A disabled port never drives: is_master and cs_in_act need enable_i
endmodule // ssp_top

// >>> design/ssp_pkg.sv
// Shared constants for the serial peripheral port
package ssp_pkg;
  // Word size selector codes
  localparam logic [1:0] WSEL_8 = 2'h0;
  localparam logic [1:0] WSEL_16 = 2'h1;
  localparam logic [1:0] WSEL_32 = 2'h2;
  // Index of the last bit of a word, per size
  localparam logic [4:0] LAST_BIT_8 = 5'h07;
  localparam logic [4:0] LAST_BIT_16 = 5'h0f;
  localparam logic [4:0] LAST_BIT_32 = 5'h1f;
  // Data path shape and buffer depth
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  // Reset values of internal state
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [5:0] EDGE_RESET = 6'h00;
  localparam logic [4:0] BIT_RESET = 5'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
endpackage

// >>> design/ssp_fifo.sv
// Word FIFO with registered head, valid and ready on both sides
module ssp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Filling side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Draining side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic move;

  // Head register is refilled whenever it is empty or being taken
  assign in_ready_o = (count != FULL_CNT);
  assign push = in_valid_i & in_ready_o;
  assign move = (count != '0) & (~out_valid_o | out_ready_i);

  // Storage array, no reset needed on data
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (move) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(move);
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (move) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // ssp_fifo

// >>> tb/ssp_checker_properties.sv
// Concurrent checks on the pins and requests of the serial peripheral port
module ssp_checker (
  // Clock, reset and configuration
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic role_select_bit_i,
  input wire logic clock_polarity_i,
  input wire logic cs_active_high_i,
  input wire logic cs_manual_i,
  input wire logic dma_tx_en_i,
  input wire logic dma_rx_en_i,
  // Observed outputs
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire logic dma_tx_req_o,
  input wire logic dma_rx_req_o,
  input wire logic busy_o,
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_line_oe_o,
  input wire logic chip_select_line_o,
  input wire logic chip_select_line_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Requests follow buffer state directly
  a_dma_tx_level: assert property (dma_tx_req_o == (dma_tx_en_i && tx_ready_o))
    else $error("tx request level wrong");
  a_dma_rx_level: assert property (dma_rx_req_o == (dma_rx_en_i && rx_valid_o))
    else $error("rx request level wrong");
  // Disabled port leaves every pin released
  a_pins_released: assert property (!enable_i [*2] |-> !(serial_clock_line_oe_o || chip_select_line_oe_o
    || mosi_oe_o || miso_oe_o))
    else $error("pin driven while disabled");
  // Slave takes clock and select from outside
  a_slave_clk_in: assert property ((enable_i && role_select_bit_i) [*2] |->
    !serial_clock_line_oe_o && !chip_select_line_oe_o && !mosi_oe_o)
    else $error("slave drives clock or select");
  a_master_drives: assert property ((enable_i && !role_select_bit_i) [*2] |->
    serial_clock_line_oe_o && chip_select_line_oe_o)
    else $error("master not driving clock and select");
  a_master_miso_in: assert property (!role_select_bit_i |-> !miso_oe_o)
    else $error("master drives its input line");
  // Two idle cycles allow for the one-cycle settle after an aborted word
  a_clk_idle_level: assert property ((!busy_o && $stable(clock_polarity_i)) [*2] |->
    serial_clock_line_o == clock_polarity_i)
    else $error("idle clock level wrong");
  a_cs_idle_level: assert property ((!busy_o && !cs_manual_i && chip_select_line_oe_o
    && $stable(cs_active_high_i)) [*2] |-> chip_select_line_o != cs_active_high_i)
    else $error("select active while idle");
  // Any clock edge needs select already active one cycle earlier
  a_select_leads: assert property (!role_select_bit_i && $stable(clock_polarity_i) && $stable(cs_active_high_i)
    && serial_clock_line_o != $past(serial_clock_line_o) |-> $past(chip_select_line_o) == cs_active_high_i)
    else $error("clock edge without leading select");
endmodule // ssp_checker

bind ssp_top ssp_checker u_ssp_checker (.*);

// >>> tb/ssp_slave_model.sv
// Behavioural external slave on the far side of the serial port
module ssp_slave_model #(
  parameter logic [31:0] SCR = 32'h5a3c_c3a5
) (
  // Serial lines
  input wire logic sclk_i,
  input wire logic sel_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Format, kept equal to the port's by the bench
  input wire logic sel_level_i,
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic [5:0] nbits_i,
  output logic [31:0] got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh = 32'h0;
  logic on = 1'b0;
  int cnt = 0;
  initial got_o = 32'h0;
  // Released line shows the inverse so a stale bit never matches by luck
  assign miso_o = (sel_i === sel_level_i) ? sh[31] : ~sh[31];
  // Reply is the last word heard, scrambled, so order slips show
  // Level input is watched too, so a moving select polarity settles to idle
  always @(sel_i, sel_level_i) begin
    on = (sel_i === sel_level_i);
    cnt = 0;
    if (on)
      sh = (got_o ^ SCR) << (6'h20 - nbits_i);
  end
  // Sample on leading edge for phase 0, trailing for phase 1; shift on the other
  always @(sclk_i) if (on) begin
    if ((sclk_i !== pol_i) ^ pha_i) begin
      got_o = {got_o[30:0], mosi_i};
      cnt++;
    end else if (!(pha_i && cnt == 0))
      sh = sh << 1;
  end
endmodule // ssp_slave_model

// >>> tb/testbench.sv
// Self-checking bench for the serial peripheral port in master and slave role
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SCR = 32'h5a3c_c3a5;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, enable_i = 1'b0, role_select_bit_i = 1'b0;
  logic clock_polarity_i = 1'b0, clock_phase_i = 1'b0, cs_active_high_i = 1'b0, cs_manual_i = 1'b0;
  logic cs_manual_assert_i = 1'b0, slave_out_disable_i = 1'b0, dma_tx_en_i = 1'b1, dma_rx_en_i = 1'b1;
  logic tx_valid_i = 1'b0, rx_ready_i = 1'b0;
  logic [1:0] word_size_i = 2'h0;
  logic [7:0] clk_div_i = 8'h00;
  logic [31:0] tx_data_i = 32'h0, rx_data_o, got, img = 32'h0;
  logic tx_ready_o, rx_valid_o, dma_tx_req_o, dma_rx_req_o, busy_o, slave_underrun_o, slave_overrun_o;
  logic serial_clock_line_o, serial_clock_line_oe_o, chip_select_line_o, chip_select_line_oe_o;
  logic mosi_o, mosi_oe_o, miso_o, miso_oe_o, mdl_miso;
  // External master levels, used once the port is a slave
  logic ext_clk = 1'b0, ext_sel = 1'b0, ext_mosi = 1'b0;
  int mismatches = 0, n_tests = 0;
  // Pin levels from all drivers; released lines go to a defined or flipped level
  wire serial_clock_line_i = serial_clock_line_oe_o ? serial_clock_line_o : clock_polarity_i ^ ext_clk;
  wire chip_select_line_i = chip_select_line_oe_o ? chip_select_line_o : cs_active_high_i ~^ ext_sel;
  wire mosi_i = mosi_oe_o ? mosi_o : (ext_sel ? ext_mosi : ~mosi_o);
  wire miso_i = miso_oe_o ? miso_o : mdl_miso;
  wire [5:0] nb = word_size_i == ssp_pkg::WSEL_8 ? 6'h08 : word_size_i == ssp_pkg::WSEL_16 ? 6'h10 : 6'h20;
  wire [31:0] msk = ~(32'hffff_ffff << nb);

  ssp_top u_ssp_top (.*);
  ssp_slave_model u_ssp_slave_model (.sclk_i(serial_clock_line_i), .sel_i(chip_select_line_i),
    .mosi_i(mosi_i), .miso_o(mdl_miso), .sel_level_i(cs_active_high_i), .pol_i(clock_polarity_i),
    .pha_i(clock_phase_i), .nbits_i(nb), .got_o(got));

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Offer one word and hold it until the edge that takes it
  task automatic push(input logic [31:0] w);
    @(posedge sys_clk_i);
    tx_data_i <= w;
    tx_valid_i <= 1'b1;
    for (int i = 0; i <= 2000; i++) begin
      @(posedge sys_clk_i);
      if (tx_ready_o === 1'b1) break;
      if (i == 2000) begin
        mismatches++;
        complete_run();
      end
    end
    tx_valid_i <= 1'b0;
  endtask

  // Take the next received word at the edge where it is valid
  task automatic pull(input logic [31:0] e);
    for (int i = 0; i <= 3000; i++) begin
      @(posedge sys_clk_i);
      if (rx_valid_o === 1'b1) break;
      if (i == 3000) begin
        mismatches++;
        complete_run();
      end
    end
    chk(rx_data_o, e);
  endtask

  // Wait for the master to drop select, so setup never changes mid-word
  task automatic idle_wait;
    for (int i = 0; i <= 1000; i++) begin
      @(posedge sys_clk_i);
      if (busy_o === 1'b0) break;
      if (i == 1000) begin
        mismatches++;
        complete_run();
      end
    end
  endtask

  // Expected reply mirrors the model: last words heard, scrambled
  task automatic xfer(input logic [31:0] t);
    push(t);
    pull((img ^ SCR) & msk);
    img = (img << nb) | (t & msk);
    chk(got & msk, t & msk);
    idle_wait();
  endtask

  // Act as external master: phase 0 frame, three system clocks per level
  task automatic sframe(input logic [15:0] w, input logic [15:0] e);
    logic [15:0] r;
    r = 16'h0;
    ext_sel <= 1'b1;
    for (int b = 15; b >= 0; b--) begin
      ext_mosi <= w[b];
      repeat (3) @(posedge sys_clk_i);
      r[b] = miso_i;
      ext_clk <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      ext_clk <= 1'b0;
    end
    repeat (3) @(posedge sys_clk_i);
    ext_sel <= 1'b0;
    chk(r, e);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 chk({serial_clock_line_oe_o, chip_select_line_oe_o, mosi_oe_o, miso_oe_o}, 32'h0);
    enable_i <= 1'b1;
    rx_ready_i <= 1'b1;
    // All four modes, all sizes, both select levels, several dividers
    for (int i = 0; i < 6; i++) begin
      // Select level moves alone, one edge before the clock format
      @(posedge sys_clk_i);
      cs_active_high_i <= i[0] ^ i[1];
      @(posedge sys_clk_i);
      {clock_phase_i, clock_polarity_i} <= i[1:0];
      word_size_i <= 2'(i % 3);
      clk_div_i <= i[7:0];
      repeat (3) @(posedge sys_clk_i);
      xfer(32'hc3a5_96e1 + i);
    end
    // Software-held select
    cs_manual_i <= 1'b1;
    cs_manual_assert_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 chk(chip_select_line_o, cs_active_high_i);
    cs_manual_assert_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 chk(chip_select_line_o, {31'h0, ~cs_active_high_i});
    cs_manual_i <= 1'b0;
    role_select_bit_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 chk(serial_clock_line_oe_o, 32'h0);
    role_select_bit_i <= 1'b0;
    // Fill the transmit side while disabled until it refuses
    enable_i <= 1'b0;
    rx_ready_i <= 1'b0;
    word_size_i <= ssp_pkg::WSEL_8;
    clk_div_i <= 8'h00;
    for (int k = 0; k < 33; k++)
      push(32'(k) * 32'h1d);
    #1 chk(tx_ready_o, 32'h0);
    @(posedge sys_clk_i);
    enable_i <= 1'b1;
    // Receive consumer stalls while all words cross
    repeat (900) @(posedge sys_clk_i);
    #1 chk({tx_ready_o, busy_o, rx_valid_o}, 32'h5);
    rx_ready_i <= 1'b1;
    for (int k = 0; k < 33; k++) begin
      pull((img ^ SCR) & 32'hff);
      img = (img << 8) | ((32'(k) * 32'h1d) & 32'hff);
    end
    @(posedge sys_clk_i);
    #1 chk(rx_valid_o, 32'h0);
    // Slave role: two words back to back inside one select
    role_select_bit_i <= 1'b1;
    rx_ready_i <= 1'b0;
    push(32'h0000_00a5);
    push(32'h0000_003c);
    sframe(16'h96e1, 16'ha53c);
    rx_ready_i <= 1'b1;
    pull(32'h0000_0096);
    pull(32'h0000_00e1);
    // Output switch keeps the reply line released inside a select
    slave_out_disable_i <= 1'b1;
    ext_sel <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(miso_oe_o, 32'h0);
    complete_run();
  end
endmodule // testbench
